// File: logic/zsh_consts.vh
// Purpose: shared constants for the zone status handshake block
// Assumes: 10 MHz system clock, 16-bit zone status words
// Notes: register offsets are the local holding register addresses
`ifndef ZSH_CONSTS_VH
`define ZSH_CONSTS_VH

// register offsets on the peer register port
`define ZSH_OFS_UP_STATUS_OUT 8'h74
`define ZSH_OFS_UP_NBR_IN 8'h86
`define ZSH_OFS_DIS_STATUS_OUT 8'hC4
`define ZSH_OFS_DN_NBR_IN 8'hE8

// zone status codes
`define ZSH_ST_CLEAR 16'h0001
`define ZSH_ST_RUN 16'h0002
`define ZSH_ST_DISCH 16'h0004
`define ZSH_ST_BLOCKED 16'h0005

// reset values of the neighbour-written registers
`define ZSH_RST_UP_NBR_IN 16'h0001
`define ZSH_RST_DN_NBR_IN 16'h0005

// field layout: low byte used when the high byte is masked
`define ZSH_LOW_BYTE_MSB 7

// timing
`define ZSH_CLK_HZ 10000000
`define ZSH_JAM_TIME_MS 2000

`endif

// File: logic/zsh_pin_sync.v
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs are asynchronous to clk
// Notes: output follows once stages two and three agree
`timescale 1ns/1ps

module zsh_pin_sync #(
	parameter WIDTH = 4
) (
	input wire clk,
	input wire arst_n,
	input wire ce,
	input wire [WIDTH-1:0] pin,
	output wire [WIDTH-1:0] level
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1)
		begin : g_bit
			// each bit keeps its own flops, so no vector has two processes driving it
			reg stage1;
			reg stage2;
			reg stage3;
			reg held;
			// stage1 feeds only stage2, so metastability never reaches the filter
			always @(posedge clk or negedge arst_n)
			begin
				if (!arst_n)
				begin
					stage1 <= 1'b0;
					stage2 <= 1'b0;
					stage3 <= 1'b0;
					held <= 1'b0;
				end
				else if (ce)
				begin
					stage1 <= pin[i];
					stage2 <= stage1;
					stage3 <= stage2;
					if (stage2 == stage3)
						held <= stage3;
				end
			end
			assign level[i] = held;
		end
	endgenerate

endmodule // zsh_pin_sync

// File: logic/zsh_zone_ctrl.v
// Purpose: two-zone carton handoff driven by neighbour status words
// Assumes: peers write our local status registers over the register port
// Notes: sensors and segment straps are pins and pass the synchroniser
`timescale 1ns/1ps
`include "zsh_consts.vh"

module zsh_zone_ctrl #(
	parameter JAM_CYCLES = `ZSH_JAM_TIME_MS * (`ZSH_CLK_HZ / 1000)
) (
	input wire clk,
	input wire arst_n,
	input wire ce,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_addr,
	input wire [15:0] reg_wdata,
	output reg [15:0] reg_rdata,
	output reg reg_rvalid,
	input wire up_sensor_pin,
	input wire dis_sensor_pin,
	input wire has_upstream_pin,
	input wire has_downstream_pin,
	input wire hi_byte_mask,
	input wire flag_clear,
	output reg up_motor_run,
	output reg dis_motor_run,
	output reg up_nbr_wr,
	output reg [15:0] up_nbr_wdata,
	output reg dn_nbr_wr,
	output reg [15:0] dn_nbr_wdata,
	output reg arrival_jam,
	output reg flex_zone
);

	localparam S_UP_IDLE = 2'h0;
	localparam S_UP_ACCEPT = 2'h1;
	localparam S_UP_LOADED = 2'h2;
	localparam S_DIS_EMPTY = 2'h0;
	localparam S_DIS_HOLD = 2'h1;
	localparam S_DIS_RELEASE = 2'h2;
	localparam S_DIS_CONFIRM = 2'h3;

	wire [3:0] pins_sync;
	reg [15:0] up_nbr_in;
	reg [15:0] dn_nbr_in;
	reg [15:0] up_nbr_prev;
	reg [15:0] up_status;
	reg [15:0] dis_status;
	reg [1:0] up_state;
	reg [1:0] dis_state;
	reg [24:0] jam_cnt;
	reg [1:0] links_prev;

	// compare a status word, ignoring the high byte when masked
	function st_is;
		input [15:0] word;
		input [15:0] code;
		input mask;
		begin
			st_is = mask ? (word[`ZSH_LOW_BYTE_MSB:0] == code[`ZSH_LOW_BYTE_MSB:0])
				: (word == code);
		end
	endfunction

	// sensors and segment straps come from outside the clock domain
	zsh_pin_sync #(
		.WIDTH(4)
	) u_sync (
		.clk(clk),
		.arst_n(arst_n),
		.ce(ce),
		.pin({has_downstream_pin, has_upstream_pin, dis_sensor_pin, up_sensor_pin}),
		.level(pins_sync)
	);

	wire up_blocked = pins_sync[0];
	wire dis_blocked = pins_sync[1];
	wire has_upstream = pins_sync[2];
	wire has_downstream = pins_sync[3];

	// neighbour status decode, evaluated every cycle
	wire dn_ready = st_is(dn_nbr_in, `ZSH_ST_CLEAR, hi_byte_mask)
		| st_is(dn_nbr_in, `ZSH_ST_RUN, hi_byte_mask);
	wire dn_busy = st_is(dn_nbr_in, `ZSH_ST_DISCH, hi_byte_mask)
		| st_is(dn_nbr_in, `ZSH_ST_BLOCKED, hi_byte_mask);
	wire up_discharging = st_is(up_nbr_in, `ZSH_ST_DISCH, hi_byte_mask);
	wire up_cleared = st_is(up_nbr_in, `ZSH_ST_CLEAR, hi_byte_mask);
	wire up_turned_4 = up_discharging & ~st_is(up_nbr_prev, `ZSH_ST_DISCH, hi_byte_mask);

	// local holding registers; peers and bridging controllers write the inputs
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			up_nbr_in <= `ZSH_RST_UP_NBR_IN;
			dn_nbr_in <= `ZSH_RST_DN_NBR_IN;
			up_nbr_prev <= `ZSH_RST_UP_NBR_IN;
			reg_rdata <= 16'h0000;
			reg_rvalid <= 1'b0;
		end
		else if (ce)
		begin
			up_nbr_prev <= up_nbr_in;
			reg_rvalid <= reg_rd;
			if (reg_wr && reg_addr == `ZSH_OFS_UP_NBR_IN)
				up_nbr_in <= reg_wdata;
			if (reg_wr && reg_addr == `ZSH_OFS_DN_NBR_IN)
				dn_nbr_in <= reg_wdata;
			if (reg_rd)
			begin
				case (reg_addr)
					`ZSH_OFS_UP_STATUS_OUT: reg_rdata <= up_status;
					`ZSH_OFS_UP_NBR_IN: reg_rdata <= up_nbr_in;
					`ZSH_OFS_DIS_STATUS_OUT: reg_rdata <= dis_status;
					`ZSH_OFS_DN_NBR_IN: reg_rdata <= dn_nbr_in;
					default: reg_rdata <= 16'h0000; // unmapped reads as zero
				endcase
			end
		end
	end

	// upstream accepting zone
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			up_state <= S_UP_IDLE;
			up_status <= `ZSH_ST_CLEAR;
			up_motor_run <= 1'b0;
			flex_zone <= 1'b0;
		end
		else if (ce)
		begin
			// a new flex event wins over a clear in the same cycle
			flex_zone <= flex_zone & ~flag_clear;
			case (up_state)
				S_UP_IDLE:
				begin
					if (up_turned_4)
					begin
						up_state <= S_UP_ACCEPT;
						up_motor_run <= 1'b1;
						up_status <= `ZSH_ST_RUN;
					end
				end
				S_UP_ACCEPT:
				begin
					if (up_blocked)
					begin
						if (!up_cleared)
							flex_zone <= 1'b1;
						up_state <= S_UP_LOADED;
					end
				end
				S_UP_LOADED:
				begin
					// feed the discharge zone only while it is empty
					if (!up_blocked)
					begin
						up_state <= S_UP_IDLE;
						up_motor_run <= 1'b0;
						up_status <= `ZSH_ST_CLEAR;
					end
					else if (dis_state == S_DIS_EMPTY && !dis_blocked)
					begin
						up_motor_run <= 1'b1;
						up_status <= `ZSH_ST_DISCH;
					end
					else
					begin
						up_motor_run <= 1'b0;
						up_status <= `ZSH_ST_BLOCKED;
					end
				end
				default:
				begin
					up_state <= S_UP_IDLE;
					up_motor_run <= 1'b0;
					up_status <= `ZSH_ST_CLEAR;
				end
			endcase
		end
	end

	// discharge zone with hold, release and arrival confirmation
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			dis_state <= S_DIS_EMPTY;
			dis_status <= `ZSH_ST_CLEAR;
			dis_motor_run <= 1'b0;
			jam_cnt <= 25'h0000000;
			arrival_jam <= 1'b0;
		end
		else if (ce)
		begin
			arrival_jam <= arrival_jam & ~flag_clear; // a jam in the same cycle wins
			case (dis_state)
				S_DIS_EMPTY:
				begin
					dis_motor_run <= up_motor_run & (up_state == S_UP_LOADED);
					dis_status <= `ZSH_ST_CLEAR;
					if (dis_blocked)
					begin
						if (dn_ready)
						begin
							dis_state <= S_DIS_RELEASE;
							dis_motor_run <= 1'b1;
							dis_status <= `ZSH_ST_DISCH;
						end
						else
						begin
							dis_state <= S_DIS_HOLD;
							dis_motor_run <= 1'b0;
							dis_status <= `ZSH_ST_BLOCKED;
						end
					end
				end
				S_DIS_HOLD:
				begin
					if (!dn_busy && dn_ready)
					begin
						dis_state <= S_DIS_RELEASE;
						dis_motor_run <= 1'b1;
						dis_status <= `ZSH_ST_DISCH;
					end
				end
				S_DIS_RELEASE:
				begin
					// carton left our sensor: wait for the far side to confirm
					if (!dis_blocked)
					begin
						dis_state <= S_DIS_CONFIRM;
						dis_motor_run <= 1'b0;
						jam_cnt <= 25'h0000000;
					end
				end
				S_DIS_CONFIRM:
				begin
					if (st_is(dn_nbr_in, `ZSH_ST_BLOCKED, hi_byte_mask))
					begin
						dis_state <= S_DIS_EMPTY;
						dis_status <= `ZSH_ST_CLEAR;
					end
					else if (jam_cnt == JAM_CYCLES[24:0] - 25'h0000001)
					begin
						arrival_jam <= 1'b1;
						dis_state <= S_DIS_EMPTY;
						dis_status <= `ZSH_ST_CLEAR;
					end
					else
						jam_cnt <= jam_cnt + 25'h0000001;
				end
				default: dis_state <= S_DIS_EMPTY; // all four codes are used
			endcase
		end
	end

	// status words go out to each present neighbour whenever they change
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			up_nbr_wr <= 1'b0;
			up_nbr_wdata <= 16'h0000;
			dn_nbr_wr <= 1'b0;
			dn_nbr_wdata <= 16'h0000;
			links_prev <= 2'h0;
		end
		else if (ce)
		begin
			// missing neighbours are never written; a strap settling high sends the word once
			links_prev <= {has_downstream, has_upstream};
			up_nbr_wr <= has_upstream & (!links_prev[0] | up_nbr_wdata != up_status);
			dn_nbr_wr <= has_downstream & (!links_prev[1] | dn_nbr_wdata != dis_status);
			up_nbr_wdata <= up_status;
			dn_nbr_wdata <= dis_status;
		end
	end

endmodule // zsh_zone_ctrl

// File: testbench/zsh_chk_properties.sv
// Purpose: port checks for the zone handshake
// Assumes: one clock; ce drops only for a short freeze
// Notes: shadows the neighbour-written words to judge handoffs
`timescale 1ns/1ps
module zsh_chk (
	input wire clk,
	input wire arst_n,
	input wire ce,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire [15:0] reg_rdata,
	input wire reg_rvalid,
	input wire dis_sensor_pin,
	input wire has_upstream_pin,
	input wire has_downstream_pin,
	input wire hi_byte_mask,
	input wire up_motor_run,
	input wire dis_motor_run,
	input wire up_nbr_wr,
	input wire dn_nbr_wr,
	input wire [15:0] dn_nbr_wdata
);
	reg [15:0] up_in;
	reg [15:0] dn_in;
	wire wr_up = ce && reg_wr && reg_addr == 8'h86;
	wire wr_dn = ce && reg_wr && reg_addr == 8'hE8;
	wire lo4 = reg_wdata[7:0] == 8'h04 && (hi_byte_mask || reg_wdata[15:8] == 8'h00);
	wire dn_stop = dn_in[7:0] == 8'h04 || dn_in[7:0] == 8'h05;
	// shadow copies, same reset values as the block so no false alarm at start
	always @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			up_in <= 16'h0001;
			dn_in <= 16'h0005;
		end
		else
		begin
			if (wr_up)
				up_in <= reg_wdata;
			if (wr_dn)
				dn_in <= reg_wdata;
		end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	chk_read_answer: assert property (ce && reg_rd |=> reg_rvalid)
		else $error("no read answer");
	chk_unmapped_zero: assert property (
		ce && reg_rd && !(reg_addr inside {8'h74, 8'h86, 8'hC4, 8'hE8}) |=> !reg_rdata)
		else $error("unmapped read not zero");
	chk_read_back: assert property (
		ce && reg_rd && !reg_wr && reg_addr == 8'h86 |=> reg_rdata == $past(up_in))
		else $error("upstream word read back wrong");
	chk_hold_carton: assert property (
		(dn_stop && dis_sensor_pin) [*8] |-> !dis_motor_run)
		else $error("carton not held");
	chk_release: assert property (
		dn_nbr_wdata == 16'h0005 && dis_sensor_pin && wr_dn && reg_wdata == 16'h0001
		|-> ##[1:6] dn_nbr_wdata == 16'h0004)
		else $error("carton not released");
	chk_accept: assert property (
		wr_up && lo4 && up_in[7:0] != 8'h04 |-> ##[1:6] up_motor_run)
		else $error("accepting zone idle");
	chk_no_dn_nbr: assert property (!has_downstream_pin [*8] |-> !dn_nbr_wr)
		else $error("write to missing downstream");
	chk_no_up_nbr: assert property (!has_upstream_pin [*8] |-> !up_nbr_wr)
		else $error("write to missing upstream");
endmodule // zsh_chk

bind zsh_zone_ctrl zsh_chk u_chk (
	.clk(clk),
	.arst_n(arst_n),
	.ce(ce),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata),
	.reg_rvalid(reg_rvalid),
	.dis_sensor_pin(dis_sensor_pin),
	.has_upstream_pin(has_upstream_pin),
	.has_downstream_pin(has_downstream_pin),
	.hi_byte_mask(hi_byte_mask),
	.up_motor_run(up_motor_run),
	.dis_motor_run(dis_motor_run),
	.up_nbr_wr(up_nbr_wr),
	.dn_nbr_wr(dn_nbr_wr),
	.dn_nbr_wdata(dn_nbr_wdata)
);

// File: testbench/zsh_bridge.sv
// Purpose: bridging controller in place of missing neighbours
// Assumes: requests change only on the falling edge
// Notes: released lines show inverted values, never the last ones
`timescale 1ns/1ps
module zsh_bridge (
	input wire clk,
	output reg reg_wr = 1'b0,
	output reg reg_rd = 1'b0,
	output reg [7:0] reg_addr = 8'h00,
	output reg [15:0] reg_wdata = 16'h0000,
	input wire [15:0] reg_rdata,
	input wire reg_rvalid
);
	// one write strobe across exactly one rising edge
	task wr(input [7:0] a, input [15:0] d);
	begin
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	end
	endtask
	// read strobe; the answer is only taken with its valid pulse
	task rd(input [7:0] a, output [15:0] d);
	begin
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		reg_addr = ~a;
		d = reg_rvalid ? reg_rdata : 16'hXXXX;
	end
	endtask
endmodule // zsh_bridge

// File: testbench/tb.sv
// Purpose: self-checking bench for the zone handshake
// Assumes: short jam count, ce high except in the freeze test
// Notes: the bridge model owns the register port
`timescale 1ns/1ps
`define CHK(n, e, g) \
	begin \
		n_compared++; \
		if ((g) !== (e)) \
		begin \
			fails++; \
			$display("unexpected %s exp %h got %h", n, e, g); \
		end \
	end
module tb;
	localparam JAM = 50;
	reg clk = 1'b0;
	reg arst_n = 1'b0;
	reg ce = 1'b1;
	reg up_sensor_pin = 1'b0;
	reg dis_sensor_pin = 1'b0;
	reg has_upstream_pin = 1'b1;
	reg has_downstream_pin = 1'b1;
	reg hi_byte_mask = 1'b0;
	reg flag_clear = 1'b0;
	wire reg_wr, reg_rd, reg_rvalid, up_motor_run, dis_motor_run;
	wire up_nbr_wr, dn_nbr_wr, arrival_jam, flex_zone;
	wire [7:0] reg_addr;
	wire [15:0] reg_wdata, reg_rdata, up_nbr_wdata, dn_nbr_wdata;
	reg [31:0] seed = 32'h0000F41C;
	reg [7:0] a;
	integer k;
	int fails = 0;
	int n_compared = 0;
	zsh_zone_ctrl #(
		.JAM_CYCLES(JAM)
	) dut (
		.clk(clk),
		.arst_n(arst_n),
		.ce(ce),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid),
		.up_sensor_pin(up_sensor_pin),
		.dis_sensor_pin(dis_sensor_pin),
		.has_upstream_pin(has_upstream_pin),
		.has_downstream_pin(has_downstream_pin),
		.hi_byte_mask(hi_byte_mask),
		.flag_clear(flag_clear),
		.up_motor_run(up_motor_run),
		.dis_motor_run(dis_motor_run),
		.up_nbr_wr(up_nbr_wr),
		.up_nbr_wdata(up_nbr_wdata),
		.dn_nbr_wr(dn_nbr_wr),
		.dn_nbr_wdata(dn_nbr_wdata),
		.arrival_jam(arrival_jam),
		.flex_zone(flex_zone)
	);
	zsh_bridge p (
		.clk(clk),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid)
	);
	// 100 ns clock
	always #50 clk = ~clk;
	// xorshift step for repeatable stimulus
	function [31:0] xs(input [31:0] s);
		reg [31:0] t;
	begin
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		xs = t ^ (t << 5);
	end
	endfunction
	// only the four status words answer a read
	function mapped(input [7:0] x);
		mapped = x == 8'h74 || x == 8'h86 || x == 8'hC4 || x == 8'hE8;
	endfunction
	task w(input integer n);
		repeat (n) @(negedge clk);
	endtask
	// count neighbour write pulses over n cycles into k
	task pulses(input integer n);
	begin
		k = 0;
		repeat (n)
		begin
			@(negedge clk);
			k = k + up_nbr_wr + dn_nbr_wr;
		end
	end
	endtask
	task rchk(input [7:0] x, input [15:0] e);
		reg [15:0] d;
	begin
		p.rd(x, d);
		`CHK("read data", e, d)
	end
	endtask
	// one-cycle pulse on the flag clear pin
	task clr;
	begin
		flag_clear = 1'b1;
		w(1);
		flag_clear = 1'b0;
		w(2);
	end
	endtask
	task results;
	begin
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	end
	endtask
	// main sequence; waits are long enough for the pin synchroniser
	initial
	begin
		w(3);
		arst_n = 1'b1;
		w(8);
		rchk(8'h86, 16'h0001);
		rchk(8'hE8, 16'h0005);
		rchk(8'hC4, 16'h0001);
		repeat (6)
		begin
			seed = xs(seed);
			a = seed[7:0];
			if (!mapped(a))
				rchk(a, 16'h0000);
			p.wr(8'h74, seed[31:16]);
			rchk(8'h74, 16'h0001);
		end
		$display("test registers done");
		dis_sensor_pin = 1'b1;
		w(12);
		`CHK("dis motor", 1'b0, dis_motor_run)
		`CHK("dn status", 16'h0005, dn_nbr_wdata)
		rchk(8'hC4, 16'h0005);
		p.wr(8'hE8, 16'h0001);
		pulses(6);
		`CHK("nbr writes", 1, k)
		`CHK("dn status", 16'h0004, dn_nbr_wdata)
		`CHK("dis motor", 1'b1, dis_motor_run)
		dis_sensor_pin = 1'b0;
		w(8);
		p.wr(8'hE8, 16'h0005);
		w(8);
		rchk(8'hC4, 16'h0001);
		$display("test handoff done");
		// arrival never confirmed, so the jam must come
		dis_sensor_pin = 1'b1;
		w(12);
		p.wr(8'hE8, 16'h0001);
		w(6);
		dis_sensor_pin = 1'b0;
		w(JAM + 20);
		`CHK("jam", 1'b1, arrival_jam)
		p.wr(8'hE8, 16'h0005);
		clr;
		`CHK("jam", 1'b0, arrival_jam)
		$display("test jam done");
		hi_byte_mask = 1'b1;
		seed = xs(seed);
		p.wr(8'h86, {seed[15:8], 8'h04});
		pulses(6);
		`CHK("up motor", 1'b1, up_motor_run)
		`CHK("nbr writes", 1, k)
		`CHK("up status", 16'h0002, up_nbr_wdata)
		rchk(8'h74, 16'h0002);
		up_sensor_pin = 1'b1;
		w(8);
		`CHK("flex", 1'b1, flex_zone)
		p.wr(8'h86, 16'h0001);
		up_sensor_pin = 1'b0;
		w(8);
		`CHK("up motor", 1'b0, up_motor_run)
		clr;
		`CHK("flex", 1'b0, flex_zone)
		$display("test accept done");
		has_upstream_pin = 1'b0;
		has_downstream_pin = 1'b0;
		w(10);
		dis_sensor_pin = 1'b1;
		p.wr(8'h86, 16'h0004);
		pulses(20);
		`CHK("nbr writes", 0, k)
		$display("test segment ends done");
		// a frozen block must ignore a write that would release the held carton
		ce = 1'b0;
		p.wr(8'hE8, 16'h0001);
		ce = 1'b1;
		rchk(8'hE8, 16'h0005);
		`CHK("dis motor", 1'b0, dis_motor_run)
		// reset again mid-run: the neighbour words return to their reset values
		arst_n = 1'b0;
		w(2);
		arst_n = 1'b1;
		w(8);
		rchk(8'hE8, 16'h0005);
		rchk(8'h86, 16'h0001);
		$display("test freeze and reset done");
		results;
	end
	// the run needs about 270 cycles
	initial
	begin
		#(3000 * 100);
		fails++;
		results;
	end
endmodule // tb
